/* File: converter_model.sv */
// behavioural model of the current and voltage converters feeding the monitor
// assumes the bench pulses send_i for one clock per conversion
`timescale 1ns/100ps
module converter_model (
   input wire logic clk_sys_i,
   input wire logic send_i,
   input wire logic [15:0] cur_i,
   input wire logic [15:0] volt_i,
   output logic valid_o,
   output logic [15:0] cur_o,
   output logic [15:0] volt_o
);
   initial begin
      valid_o = 1'b0;
      cur_o = 16'h5A5A;
      volt_o = 16'hA5A5;
   end
   // outside a result the lines toggle, so a stale value is never read as valid
   always @(posedge clk_sys_i) begin
      valid_o <= send_i;
      cur_o <= send_i ? cur_i : ~cur_o;
      volt_o <= send_i ? volt_i : ~volt_o;
   end
endmodule // converter_model

/* File: current_adc_result_monitor.sv */
// result post-processing for the current channel: accumulator, threshold comparator,
// over-range detector, paired fifo and result counter, with an axi4-lite register slave
// assumes converter results arrive as one-cycle valid pulses synchronous to clk_sys_i
`timescale 1ns/100ps
module current_adc_result_monitor #(
   parameter int FIFO_DEPTH = current_monitor_pkg::FIFO_DEPTH,
   parameter int OVER_RANGE_CYCLES = current_monitor_pkg::OVER_RANGE_CYCLES
) (
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire logic [7:0] s_axi_awaddr_i,
   input wire logic s_axi_awvalid_i,
   output logic s_axi_awready_o,
   input wire logic [31:0] s_axi_wdata_i,
   input wire logic [3:0] s_axi_wstrb_i,
   input wire logic s_axi_wvalid_i,
   output logic s_axi_wready_o,
   output logic [1:0] s_axi_bresp_o,
   output logic s_axi_bvalid_o,
   input wire logic s_axi_bready_i,
   input wire logic [7:0] s_axi_araddr_i,
   input wire logic s_axi_arvalid_i,
   output logic s_axi_arready_o,
   output logic [31:0] s_axi_rdata_o,
   output logic [1:0] s_axi_rresp_o,
   output logic s_axi_rvalid_o,
   input wire logic s_axi_rready_i,
   input wire logic cur_valid_i,
   input wire logic [15:0] cur_result_i,
   input wire logic cur_over_range_i,
   input wire logic volt_valid_i,
   input wire logic [15:0] volt_result_i,
   input wire logic temp_valid_i,
   input wire logic [15:0] temp_result_i,
   output logic cur_irq_o
);
   localparam int AW = $clog2(FIFO_DEPTH);
   localparam int CW = $clog2(OVER_RANGE_CYCLES + 1);

   // register state
   logic [7:0] config_reg, next_config_reg;
   logic [15:0] count_limit, next_count_limit;
   logic [15:0] threshold, next_threshold;
   logic [7:0] thr_limit, next_thr_limit;
   logic [31:0] acc_threshold, next_acc_threshold;
   // datapath state
   logic [15:0] cur_data, next_cur_data, volt_data, next_volt_data, temp_data, next_temp_data;
   logic [2:0] ready, next_ready;
   logic thr_flag, next_thr_flag, or_flag, next_or_flag, acc_flag, next_acc_flag;
   logic [15:0] result_count, next_result_count;
   logic [7:0] thr_count, next_thr_count;
   logic signed [31:0] accum, next_accum;
   logic [CW-1:0] or_cycles, next_or_cycles;
   logic [AW-1:0] wr_ptr, next_wr_ptr, rd_ptr, next_rd_ptr;
   logic [AW:0] fifo_level, next_fifo_level;
   logic pend_volt, next_pend_volt;
   // bus state
   logic aw_held, next_aw_held, w_held, next_w_held;
   logic [7:0] aw_addr, next_aw_addr;
   logic [31:0] w_data, next_w_data;
   logic [3:0] w_strb, next_w_strb;
   logic bvalid, next_bvalid, rvalid, next_rvalid;
   logic [1:0] bresp, next_bresp, rresp, next_rresp;
   logic [31:0] rdata, next_rdata;
   logic [31:0] fifo_rd_data;

   function automatic logic is_mapped(input logic [7:0] addr);
      is_mapped = (addr[1:0] == 2'h0) && (addr <= current_monitor_pkg::ADDR_RECONFIG);
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                         input logic [3:0] strb);
      for (int i = 0; i < 4; i++) begin
         merge[i*8 +: 8] = strb[i] ? data[i*8 +: 8] : old[i*8 +: 8];
      end
   endfunction

   // two's complement magnitude; the most negative code gives 16'h8000
   function automatic logic [15:0] magnitude(input logic [15:0] v);
      magnitude = v[15] ? 16'(~v + 16'h0001) : v;
   endfunction

   logic [1:0] acc_mode, cmp_mode;
   logic do_write, do_read, fifo_en, fifo_push, fifo_pop, cur_above, count_hit;
   logic [15:0] cur_mag;
   assign acc_mode = config_reg[current_monitor_pkg::CFG_ACC_LO +: 2];
   assign cmp_mode = config_reg[current_monitor_pkg::CFG_CMP_LO +: 2];
   assign fifo_en = config_reg[current_monitor_pkg::CFG_FIFO_EN];
   assign do_write = aw_held && w_held && !bvalid;
   assign do_read = s_axi_arvalid_i && !rvalid;
   assign cur_mag = magnitude(cur_result_i);
   assign cur_above = cur_mag >= threshold;
   assign count_hit = (16'(result_count + 16'h0001) >= count_limit);
   assign fifo_pop = do_read && s_axi_araddr_i == current_monitor_pkg::ADDR_FIFO
                     && fifo_level != '0;
   // a pair is pushed when a current result arrives with or after its voltage half; overfilling wraps the pointer
   assign fifo_push = fifo_en && ((cur_valid_i && (pend_volt || volt_valid_i)));

   assign s_axi_awready_o = !aw_held;
   assign s_axi_wready_o = !w_held;
   assign s_axi_arready_o = !rvalid;
   assign s_axi_bvalid_o = bvalid;
   assign s_axi_bresp_o = bresp;
   assign s_axi_rvalid_o = rvalid;
   assign s_axi_rresp_o = rresp;
   assign s_axi_rdata_o = rdata;
   assign cur_irq_o = ready[current_monitor_pkg::STA_CUR_READY] | thr_flag | or_flag | acc_flag;

   pair_fifo_mem #(.WIDTH(32), .DEPTH(FIFO_DEPTH), .AW(AW)) u_fifo (
      .clk_sys_i(clk_sys_i),
      .wr_en_i(fifo_push),
      .wr_addr_i(wr_ptr),
      .wr_data_i({volt_valid_i ? volt_result_i : volt_data, cur_result_i}),
      .rd_addr_i(next_rd_ptr),
      .rd_data_o(fifo_rd_data)
   );

   logic [31:0] status_word;
   always_comb begin
      status_word = '0;
      status_word[2:0] = ready;
      status_word[current_monitor_pkg::STA_THRESHOLD] = thr_flag;
      status_word[current_monitor_pkg::STA_OVER_RANGE] = or_flag;
      status_word[current_monitor_pkg::STA_ACC_CMP] = acc_flag;
      status_word[current_monitor_pkg::STA_FIFO_EMPTY] = fifo_level == '0;
      status_word[current_monitor_pkg::STA_FIFO_HALF] = fifo_level >= (AW+1)'(FIFO_DEPTH / 2);
      status_word[current_monitor_pkg::STA_FIFO_FULL] = fifo_level >= (AW+1)'(FIFO_DEPTH);
   end

   always_comb begin
      logic [31:0] wv;
      logic reconfig;
      logic clr_status;
      logic signed [31:0] acc_sum;
      wv = '0;
      reconfig = 1'b0;
      clr_status = 1'b0;
      acc_sum = '0;
      next_config_reg = config_reg;
      next_count_limit = count_limit;
      next_threshold = threshold;
      next_thr_limit = thr_limit;
      next_acc_threshold = acc_threshold;
      next_cur_data = cur_data;
      next_volt_data = volt_data;
      next_temp_data = temp_data;
      next_ready = ready;
      next_thr_flag = thr_flag;
      next_or_flag = or_flag;
      next_acc_flag = acc_flag;
      next_result_count = result_count;
      next_thr_count = thr_count;
      next_accum = accum;
      next_or_cycles = or_cycles;
      next_wr_ptr = wr_ptr;
      next_rd_ptr = rd_ptr;
      next_fifo_level = fifo_level;
      next_pend_volt = pend_volt;
      next_aw_held = aw_held;
      next_aw_addr = aw_addr;
      next_w_held = w_held;
      next_w_data = w_data;
      next_w_strb = w_strb;
      next_bvalid = bvalid;
      next_bresp = bresp;
      next_rvalid = rvalid;
      next_rresp = rresp;
      next_rdata = rdata;

      // write channel: address and data taken in either order
      if (s_axi_awvalid_i && !aw_held) begin
         next_aw_held = 1'b1;
         next_aw_addr = s_axi_awaddr_i;
      end
      if (s_axi_wvalid_i && !w_held) begin
         next_w_held = 1'b1;
         next_w_data = s_axi_wdata_i;
         next_w_strb = s_axi_wstrb_i;
      end
      if (bvalid && s_axi_bready_i) begin
         next_bvalid = 1'b0;
      end
      if (do_write) begin
         next_aw_held = 1'b0;
         next_w_held = 1'b0;
         next_bvalid = 1'b1;
         next_bresp = is_mapped(aw_addr) ? current_monitor_pkg::RESP_OKAY
                                         : current_monitor_pkg::RESP_SLVERR;
         unique case (aw_addr)
            current_monitor_pkg::ADDR_CONFIG: begin
               next_config_reg = 8'(merge({24'h000000, config_reg}, w_data, w_strb));
               reconfig = 1'b1;
            end
            current_monitor_pkg::ADDR_STATUS: begin
               // write one to clear sticky flags
               wv = w_strb[0] ? w_data : 32'h00000000;
               clr_status = 1'b1;
            end
            current_monitor_pkg::ADDR_COUNT_LIMIT:
               next_count_limit = 16'(merge({16'h0000, count_limit}, w_data, w_strb));
            current_monitor_pkg::ADDR_THRESHOLD:
               next_threshold = 16'(merge({16'h0000, threshold}, w_data, w_strb));
            current_monitor_pkg::ADDR_THR_LIMIT:
               next_thr_limit = 8'(merge({24'h000000, thr_limit}, w_data, w_strb));
            current_monitor_pkg::ADDR_ACC_THRESHOLD:
               next_acc_threshold = merge(acc_threshold, w_data, w_strb);
            current_monitor_pkg::ADDR_RECONFIG: reconfig = 1'b1;
            default: ;
         endcase
      end
      if (reconfig) begin
         next_result_count = '0;
      end
      if (clr_status) begin
         if (wv[current_monitor_pkg::STA_THRESHOLD]) next_thr_flag = 1'b0;
         if (wv[current_monitor_pkg::STA_OVER_RANGE]) next_or_flag = 1'b0;
         if (wv[current_monitor_pkg::STA_ACC_CMP]) next_acc_flag = 1'b0;
      end

      // read channel; a current data read clears all ready flags
      if (rvalid && s_axi_rready_i) begin
         next_rvalid = 1'b0;
      end
      if (do_read) begin
         next_rvalid = 1'b1;
         next_rresp = is_mapped(s_axi_araddr_i) ? current_monitor_pkg::RESP_OKAY
                                                : current_monitor_pkg::RESP_SLVERR;
         next_rdata = '0;
         unique case (s_axi_araddr_i)
            current_monitor_pkg::ADDR_CONFIG: next_rdata[7:0] = config_reg;
            current_monitor_pkg::ADDR_STATUS: next_rdata = status_word;
            current_monitor_pkg::ADDR_CUR_DATA: begin
               next_rdata[15:0] = cur_data;
               next_ready = '0;
            end
            current_monitor_pkg::ADDR_VOLT_DATA: next_rdata[15:0] = volt_data;
            current_monitor_pkg::ADDR_TEMP_DATA: next_rdata[15:0] = temp_data;
            current_monitor_pkg::ADDR_COUNT_LIMIT: next_rdata[15:0] = count_limit;
            current_monitor_pkg::ADDR_COUNT: next_rdata[15:0] = result_count;
            current_monitor_pkg::ADDR_THRESHOLD: next_rdata[15:0] = threshold;
            current_monitor_pkg::ADDR_THR_LIMIT: next_rdata[7:0] = thr_limit;
            current_monitor_pkg::ADDR_THR_COUNT: next_rdata[7:0] = thr_count;
            current_monitor_pkg::ADDR_ACCUM: next_rdata = accum;
            current_monitor_pkg::ADDR_ACC_THRESHOLD: next_rdata = acc_threshold;
            default: ;
         endcase
      end
      if (fifo_pop) begin
         next_rd_ptr = AW'(rd_ptr + 1'b1);
      end

      // voltage and temperature keep their newest result only
      if (volt_valid_i) begin
         next_volt_data = volt_result_i;
         next_ready[current_monitor_pkg::STA_VOLT_READY] = 1'b1;
         next_pend_volt = !cur_valid_i;
      end
      if (temp_valid_i) begin
         next_temp_data = temp_result_i;
         next_ready[current_monitor_pkg::STA_TEMP_READY] = 1'b1;
      end

      if (cur_valid_i) begin
         next_cur_data = cur_result_i;
         if (config_reg[current_monitor_pkg::CFG_RESULT_COUNT_EN]) begin
            if (count_hit) begin
               next_result_count = '0;
               next_ready[current_monitor_pkg::STA_CUR_READY] = 1'b1;
            end else begin
               next_result_count = 16'(result_count + 16'h0001);
            end
         end else begin
            next_ready[current_monitor_pkg::STA_CUR_READY] = 1'b1;
         end
         if (fifo_push) begin
            next_pend_volt = 1'b0;
         end

         // accumulator
         unique case (acc_mode)
            current_monitor_pkg::MODE_OFF: next_accum = '0;
            current_monitor_pkg::MODE_01: begin
               acc_sum = accum + 32'(signed'(cur_result_i));
               next_accum = acc_sum[31] ? 32'sh00000000 : acc_sum;
            end
            current_monitor_pkg::MODE_10, current_monitor_pkg::MODE_11:
               next_accum = accum + 32'(signed'(cur_result_i));
         endcase
         if (acc_mode == current_monitor_pkg::MODE_11 &&
             $signed(next_accum) >= $signed(acc_threshold)) begin
            next_acc_flag = 1'b1;
         end

         // threshold comparator
         unique case (cmp_mode)
            current_monitor_pkg::MODE_OFF: next_thr_count = '0;
            current_monitor_pkg::MODE_01: if (cur_above) next_thr_flag = 1'b1;
            current_monitor_pkg::MODE_10, current_monitor_pkg::MODE_11: begin
               if (cur_above) begin
                  if (thr_count != 8'hFF) next_thr_count = 8'(thr_count + 8'h01);
                  if (8'(thr_count + 8'h01) >= thr_limit) next_thr_flag = 1'b1;
               end else if (cmp_mode == current_monitor_pkg::MODE_10) begin
                  next_thr_count = '0;
               end else if (thr_count != '0) begin
                  next_thr_count = 8'(thr_count - 8'h01);
               end
            end
         endcase
      end else if (cmp_mode == current_monitor_pkg::MODE_OFF) begin
         next_thr_count = '0;
      end

      // a disabled accumulator is held at zero even with no result arriving
      if (acc_mode == current_monitor_pkg::MODE_OFF) begin
         next_accum = '0;
      end

      // over-range: flag after the condition stands past the time limit
      if (config_reg[current_monitor_pkg::CFG_OVER_RANGE_EN] && cur_over_range_i) begin
         if (or_cycles < CW'(OVER_RANGE_CYCLES)) begin
            next_or_cycles = CW'(or_cycles + 1'b1);
         end else begin
            next_or_flag = 1'b1;
         end
      end else begin
         next_or_cycles = '0;
      end

      // fifo pointers; overfill wraps and corrupts the oldest entries
      if (fifo_push) begin
         next_wr_ptr = AW'(wr_ptr + 1'b1);
      end
      if (!fifo_en) begin
         next_wr_ptr = '0;
         next_rd_ptr = '0;
         next_fifo_level = '0;
         next_pend_volt = 1'b0;
      end else if (fifo_push && !fifo_pop) begin
         if (fifo_level != (AW+1)'(FIFO_DEPTH)) next_fifo_level = (AW+1)'(fifo_level + 1'b1);
      end else if (fifo_pop && !fifo_push) begin
         next_fifo_level = (AW+1)'(fifo_level - 1'b1);
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         config_reg <= current_monitor_pkg::CONFIG_RESET;
         count_limit <= current_monitor_pkg::COUNT_LIMIT_RESET;
         threshold <= '0;
         thr_limit <= current_monitor_pkg::THR_LIMIT_RESET;
         acc_threshold <= '0;
         cur_data <= '0;
         volt_data <= '0;
         temp_data <= '0;
         ready <= '0;
         thr_flag <= 1'b0;
         or_flag <= 1'b0;
         acc_flag <= 1'b0;
         result_count <= '0;
         thr_count <= '0;
         accum <= '0;
         or_cycles <= '0;
         wr_ptr <= '0;
         rd_ptr <= '0;
         fifo_level <= '0;
         pend_volt <= 1'b0;
         aw_held <= 1'b0;
         aw_addr <= '0;
         w_held <= 1'b0;
         w_data <= '0;
         w_strb <= '0;
         bvalid <= 1'b0;
         bresp <= '0;
         rvalid <= 1'b0;
         rresp <= '0;
         rdata <= '0;
      end else begin
         config_reg <= next_config_reg;
         count_limit <= next_count_limit;
         threshold <= next_threshold;
         thr_limit <= next_thr_limit;
         acc_threshold <= next_acc_threshold;
         cur_data <= next_cur_data;
         volt_data <= next_volt_data;
         temp_data <= next_temp_data;
         ready <= next_ready;
         thr_flag <= next_thr_flag;
         or_flag <= next_or_flag;
         acc_flag <= next_acc_flag;
         result_count <= next_result_count;
         thr_count <= next_thr_count;
         accum <= next_accum;
         or_cycles <= next_or_cycles;
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
         fifo_level <= next_fifo_level;
         pend_volt <= next_pend_volt;
         aw_held <= next_aw_held;
         aw_addr <= next_aw_addr;
         w_held <= next_w_held;
         w_data <= next_w_data;
         w_strb <= next_w_strb;
         bvalid <= next_bvalid;
         bresp <= next_bresp;
         rvalid <= next_rvalid;
         rresp <= next_rresp;
         rdata <= fifo_pop ? fifo_rd_data : next_rdata;
      end
   end
endmodule // current_adc_result_monitor

/* File: current_adc_result_monitor_properties.sv */
// bus and interrupt checks for the result monitor
// bound to every monitor instance; sees its ports only
`timescale 1ns/100ps
module current_adc_result_monitor_properties (
   input wire logic clk_sys_i, rst_i, cur_valid_i, cur_over_range_i, cur_irq_o,
   input wire logic s_axi_awvalid_i, s_axi_awready_o, s_axi_wvalid_i, s_axi_wready_o,
   input wire logic s_axi_bvalid_o, s_axi_bready_i, s_axi_arvalid_i, s_axi_arready_o,
   input wire logic s_axi_rvalid_o, s_axi_rready_i,
   input wire logic [1:0] s_axi_bresp_o,
   input wire logic [31:0] s_axi_rdata_o
);
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (rst_i);
   chk_b_stands: assert property (s_axi_bvalid_o && !s_axi_bready_i
      |=> s_axi_bvalid_o && $stable(s_axi_bresp_o)) else $error("write response dropped");
   chk_r_stands: assert property (s_axi_rvalid_o && !s_axi_rready_i
      |=> s_axi_rvalid_o && $stable(s_axi_rdata_o)) else $error("read data dropped");
   chk_ar_refused: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
      else $error("read address taken while busy");
   chk_read_answer: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
      else $error("read answer late");
   chk_write_answer: assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i
      && s_axi_wready_o |-> ##[1:2] s_axi_bvalid_o) else $error("write answer late");
   chk_w_refused: assert property (s_axi_wvalid_i && s_axi_wready_o |=> !s_axi_wready_o)
      else $error("write data taken while one is held");
   chk_aw_refused: assert property (s_axi_awvalid_i && s_axi_awready_o |=> !s_axi_awready_o)
      else $error("write address taken while one is held");
   chk_resp_code: assert property (s_axi_bvalid_o |-> s_axi_bresp_o inside {2'h0, 2'h2})
      else $error("bad write response");
   chk_irq_cause: assert property ($rose(cur_irq_o) |-> $past(cur_valid_i) ||
      $past(cur_valid_i, 2) || $past(cur_valid_i, 3) || $past(cur_over_range_i))
      else $error("interrupt without cause");
   chk_irq_clear: assert property ($fell(cur_irq_o) |-> s_axi_bvalid_o || s_axi_rvalid_o)
      else $error("interrupt dropped without access");
endmodule // current_adc_result_monitor_properties
bind current_adc_result_monitor current_adc_result_monitor_properties chk (.*);

/* File: current_adc_result_monitor_test.sv */
// self-checking bench for the result monitor
// reads queue their expectation; a monitor process compares on rvalid
`timescale 1ns/100ps
module current_adc_result_monitor_test;
   localparam int ORC = 8;
   `define CHK(n, e, g) begin n_tests++; if ((e) !== (g)) begin n_mismatch++; \
      $display("MISMATCH %s exp %h got %h", n, e, g); end end
   logic clk = 0, rst = 1, awv = 0, wv = 0, arv = 0, sd = 0, ovr = 0, vld, irq;
   logic awr, wrdy, bv, arr, rv;
   logic [7:0] awa = 0, ara = 0;
   logic [31:0] wd = 0, rdat, lf = 32'hA73C;
   logic [15:0] cv = 0, vv = 0, cres, vres, v;
   logic [1:0] bresp, rresp;
   logic [65:0] x, q[$];
   int n_tests = 0, n_mismatch = 0, cyc = 0, md;
   always #4 clk = ~clk;
   converter_model pm (.clk_sys_i(clk), .send_i(sd), .cur_i(cv), .volt_i(vv), .valid_o(vld),
      .cur_o(cres), .volt_o(vres));
   current_adc_result_monitor #(.OVER_RANGE_CYCLES(ORC)) DUT (.clk_sys_i(clk), .rst_i(rst),
      .s_axi_awaddr_i(awa), .s_axi_awvalid_i(awv), .s_axi_awready_o(awr), .s_axi_wdata_i(wd),
      .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wv), .s_axi_wready_o(wrdy), .s_axi_bresp_o(bresp),
      .s_axi_bvalid_o(bv), .s_axi_bready_i(1'b1), .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv),
      .s_axi_arready_o(arr), .s_axi_rdata_o(rdat), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rv),
      .s_axi_rready_i(1'b1), .cur_valid_i(vld), .cur_result_i(cres), .cur_over_range_i(ovr),
      .volt_valid_i(vld), .volt_result_i(vres), .temp_valid_i(vld), .temp_result_i(vres),
      .cur_irq_o(irq));
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      awa <= a; wd <= d; awv <= 1'b1; wv <= 1'b1;
      do begin @(posedge clk); if (awr) awv <= 1'b0; if (wrdy) wv <= 1'b0; end while (!bv);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e, m, input logic [1:0] r = 0);
      q.push_back({r, m, e}); ara <= a; arv <= 1'b1;
      do begin @(posedge clk); if (arr) arv <= 1'b0; end while (!rv);
   endtask
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // volt side gets pseudo-random values so pairing slips show up
   task automatic snd(input logic [15:0] c);
      lf = lfsr(lf);
      sd <= 1'b1; cv <= c; vv <= lf[15:0];
      @(posedge clk); sd <= 1'b0; repeat (3) @(posedge clk);
   endtask
   task end_of_test;
      $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   always @(posedge clk) if (rv) begin
      x = q.pop_front();
      `CHK("rdata", x[31:0], rdat & x[63:32])
      `CHK("rresp", x[65:64], rresp)
   end
   always @(posedge clk) if (++cyc == 6000) begin n_mismatch++; end_of_test; end
   initial begin
      repeat (4) @(posedge clk); rst <= 1'b0; @(posedge clk);
      rd(current_monitor_pkg::ADDR_CONFIG, 0, 32'hFF);
      rd(current_monitor_pkg::ADDR_COUNT_LIMIT, 1, 32'hFFFF);
      rd(8'h3C, 0, '1, current_monitor_pkg::RESP_SLVERR);
      $display("reset test done");
      wr(current_monitor_pkg::ADDR_ACC_THRESHOLD, 50);
      for (int m = 0; m < 4; m++) begin
         wr(current_monitor_pkg::ADDR_CONFIG, 0); wr(current_monitor_pkg::ADDR_STATUS, 32'h38);
         wr(current_monitor_pkg::ADDR_CONFIG, m << 5); snd(16'h0064); snd(16'hFED4);
         rd(current_monitor_pkg::ADDR_ACCUM, m > 1 ? 32'hFFFFFF38 : 0, '1);
         rd(current_monitor_pkg::ADDR_STATUS, (m == 3) << 5, 32'h28);
      end
      $display("accumulator test done");
      wr(current_monitor_pkg::ADDR_THRESHOLD, 1000); wr(current_monitor_pkg::ADDR_THR_LIMIT, 3);
      for (int c = 2; c < 5; c++) begin
         md = c == 4 ? 1 : c;
         wr(current_monitor_pkg::ADDR_CONFIG, 0);
         wr(current_monitor_pkg::ADDR_CONFIG, md << 3); wr(current_monitor_pkg::ADDR_STATUS, 32'h38);
         snd(16'h03E8); snd(16'hFC18); snd(16'hFC19); snd(16'h03E8); snd(16'h03E8);
         rd(current_monitor_pkg::ADDR_STATUS, (md != 2) << 3, 32'h8);
         if (md > 1) rd(current_monitor_pkg::ADDR_THR_COUNT, md, 32'hFF);
      end
      $display("comparator test done");
      wr(current_monitor_pkg::ADDR_COUNT_LIMIT, 3); wr(current_monitor_pkg::ADDR_CONFIG, 1);
      wr(current_monitor_pkg::ADDR_STATUS, 32'h38);
      rd(current_monitor_pkg::ADDR_CUR_DATA, 0, 0); snd(16'h0011); snd(16'h0022);
      rd(current_monitor_pkg::ADDR_STATUS, 0, 32'h1);
      `CHK("irq", 0, irq)
      rd(current_monitor_pkg::ADDR_COUNT, 2, 32'hFFFF);
      snd(16'h0033); rd(current_monitor_pkg::ADDR_STATUS, 1, 32'h1);
      `CHK("irq", 1, irq)
      rd(current_monitor_pkg::ADDR_COUNT, 0, 32'hFFFF);
      rd(current_monitor_pkg::ADDR_VOLT_DATA, lf[15:0], 32'hFFFF);
      rd(current_monitor_pkg::ADDR_CUR_DATA, 16'h0033, 32'hFFFF);
      snd(16'h0044); wr(current_monitor_pkg::ADDR_RECONFIG, 0);
      rd(current_monitor_pkg::ADDR_COUNT, 0, 32'hFFFF);
      $display("result counter test done");
      wr(current_monitor_pkg::ADDR_CONFIG, 4);
      for (int k = ORC; k <= ORC + 1; k++) begin
         ovr <= 1'b1; repeat (k) @(posedge clk); ovr <= 1'b0; @(posedge clk);
         rd(current_monitor_pkg::ADDR_STATUS, (k > ORC) << 4, 32'h10);
      end
      $display("over-range test done");
      wr(current_monitor_pkg::ADDR_CONFIG, 2);
      rd(current_monitor_pkg::ADDR_STATUS, 32'h40, 32'h1C0);
      snd(16'h0005); v = lf[15:0]; snd(16'h0006);
      rd(current_monitor_pkg::ADDR_STATUS, 0, 32'h1C0);
      rd(current_monitor_pkg::ADDR_FIFO, {v, 16'h0005}, '1);
      rd(current_monitor_pkg::ADDR_FIFO, {lf[15:0], 16'h0006}, '1);
      rd(current_monitor_pkg::ADDR_STATUS, 32'h40, 32'h1C0);
      $display("fifo test done");
      repeat (2) @(posedge clk);
      end_of_test;
   end
endmodule // current_adc_result_monitor_test

/* File: current_monitor_pkg.sv */
// constants for the current-channel result monitor: register map, field positions, reset values
// assumes a 32-bit axi4-lite register bus and a 125 MHz system clock
package current_monitor_pkg;
   localparam logic [7:0] ADDR_CONFIG = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [7:0] ADDR_CUR_DATA = 8'h08;
   localparam logic [7:0] ADDR_VOLT_DATA = 8'h0C;
   localparam logic [7:0] ADDR_TEMP_DATA = 8'h10;
   localparam logic [7:0] ADDR_FIFO = 8'h14;
   localparam logic [7:0] ADDR_COUNT_LIMIT = 8'h18;
   localparam logic [7:0] ADDR_COUNT = 8'h1C;
   localparam logic [7:0] ADDR_THRESHOLD = 8'h20;
   localparam logic [7:0] ADDR_THR_LIMIT = 8'h24;
   localparam logic [7:0] ADDR_THR_COUNT = 8'h28;
   localparam logic [7:0] ADDR_ACCUM = 8'h2C;
   localparam logic [7:0] ADDR_ACC_THRESHOLD = 8'h30;
   localparam logic [7:0] ADDR_RECONFIG = 8'h34;
   localparam int CFG_RESULT_COUNT_EN = 0;
   localparam int CFG_FIFO_EN = 1;
   localparam int CFG_OVER_RANGE_EN = 2;
   localparam int CFG_CMP_LO = 3;
   localparam int CFG_ACC_LO = 5;
   localparam int STA_CUR_READY = 0;
   localparam int STA_VOLT_READY = 1;
   localparam int STA_TEMP_READY = 2;
   localparam int STA_THRESHOLD = 3;
   localparam int STA_OVER_RANGE = 4;
   localparam int STA_ACC_CMP = 5;
   localparam int STA_FIFO_EMPTY = 6;
   localparam int STA_FIFO_HALF = 7;
   localparam int STA_FIFO_FULL = 8;
   localparam logic [7:0] CONFIG_RESET = 8'h00;
   localparam logic [15:0] COUNT_LIMIT_RESET = 16'h0001;
   localparam logic [7:0] THR_LIMIT_RESET = 8'h01;
   localparam logic [1:0] MODE_OFF = 2'h0;
   localparam logic [1:0] MODE_01 = 2'h1;
   localparam logic [1:0] MODE_10 = 2'h2;
   localparam logic [1:0] MODE_11 = 2'h3;
   localparam int FIFO_DEPTH = 32;
   localparam int CLK_MHZ = 125;
   localparam int OVER_RANGE_US = 125;
   // 125 us at the system clock; benches pass a much shorter count
   localparam int OVER_RANGE_CYCLES = OVER_RANGE_US * CLK_MHZ;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* File: pair_fifo_mem.sv */
// dual-address memory for the paired current/voltage fifo
// one write and one registered read per clock; pointers kept by the caller
`timescale 1ns/100ps
module pair_fifo_mem #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 32,
   parameter int AW = 5
) (
   input wire logic clk_sys_i,
   input wire logic wr_en_i,
   input wire logic [AW-1:0] wr_addr_i,
   input wire logic [WIDTH-1:0] wr_data_i,
   input wire logic [AW-1:0] rd_addr_i,
   output logic [WIDTH-1:0] rd_data_o
);
   logic [WIDTH-1:0] mem [DEPTH];
   always_ff @(posedge clk_sys_i) begin
      if (wr_en_i) begin
         mem[wr_addr_i] <= wr_data_i;
      end
      rd_data_o <= mem[rd_addr_i];
   end
endmodule // pair_fifo_mem
